// *** pkg/hpp_pkg.sv ***
// constants, types and helpers shared by the host port block
// assumes one 250 MHz clock (mclk) and a synchronous active-high reset
package hpp_pkg;

  // ----------------------------------------
  // widths and rates
  // ----------------------------------------
  localparam int HPP_HALF_W = 16;
  localparam int HPP_WORD_W = 32;
  localparam int HPP_CLK_MHZ = 250;

  // ----------------------------------------
  // host register select codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    HPP_SEL_CTRL     = 2'b00,
    HPP_SEL_ADDR     = 2'b01,
    HPP_SEL_DATA_INC = 2'b10,
    HPP_SEL_DATA     = 2'b11
  } hpp_sel_t;

  // boot modes taken from the straps
  typedef enum logic [1:0] {
    HPP_BOOT_HOST  = 2'b00,
    HPP_BOOT_ROM8  = 2'b01,
    HPP_BOOT_ROM16 = 2'b10,
    HPP_BOOT_ROM32 = 2'b11
  } hpp_boot_t;

  // access sequencer states
  typedef enum logic {
    HPP_ST_IDLE = 1'b0,
    HPP_ST_MEM  = 1'b1
  } hpp_state_t;

  // ----------------------------------------
  // strap positions on the host data bus
  // ----------------------------------------
  localparam int HPP_ENDIAN_STRAP_POS = 8;
  localparam int HPP_BOOT_HI_POS = 4;
  localparam int HPP_BOOT_LO_POS = 3;

  // ----------------------------------------
  // software register map (byte offsets) and fields
  // ----------------------------------------
  localparam int HPP_REG_AW = 4;
  localparam logic [3:0] HPP_REG_STATUS = 4'h0;
  localparam logic [3:0] HPP_REG_MASK = 4'h4;
  localparam logic [3:0] HPP_REG_CONTROL = 4'h8;
  localparam logic [3:0] HPP_REG_STRAPS = 4'hC;
  localparam int HPP_EV_W = 3;
  localparam int HPP_EV_WORD_WR = 0;
  localparam int HPP_EV_WORD_RD = 1;
  localparam int HPP_EV_HOST_ACK = 2;
  localparam int HPP_CTL_IRQ_BIT = 0;
  localparam int HPP_CTL_ENDIAN_BIT = 1;
  localparam int HPP_CTL_BOOT_POS = 2;

  // ----------------------------------------
  // reset values and steps
  // ----------------------------------------
  localparam logic [HPP_EV_W-1:0] HPP_MASK_RESET = 3'h0;
  localparam logic [31:0] HPP_ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] HPP_ADDR_STEP = 32'h0000_0004;
  localparam logic [15:0] HPP_HALF_ZERO = 16'h0000;

  // picks the first or second half of a word for the current byte order
  function automatic logic [15:0] hpp_half_of(input logic [31:0] word, input logic second,
                                              input logic little);
    hpp_half_of = (second ^ little) ? word[15:0] : word[31:16];
  endfunction

  // joins first and second half into a word for the current byte order
  function automatic logic [31:0] hpp_join(input logic [15:0] first, input logic [15:0] second,
                                           input logic little);
    hpp_join = little ? {second, first} : {first, second};
  endfunction

endpackage

// *** rtl/hpp_strap_latch.sv ***
// catches endian and boot straps from the host data bus during reset
// assumes the straps are stable on the bus while reset is high
module hpp_strap_latch
  import hpp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // strap source
  input wire logic [hpp_pkg::HPP_HALF_W-1:0] host_data_in,
  // captured configuration
  output logic endian_little,
  output hpp_pkg::hpp_boot_t boot_mode
);

  typedef struct packed {
    logic little;
    hpp_boot_t boot;
  } hpp_strap_st_t;

  hpp_strap_st_t st;
  hpp_strap_st_t next_st;

  // follow the bus while reset is high, freeze on release
  always_comb
  begin
    next_st = st;
    if (reset)
    begin
      next_st.little = host_data_in[HPP_ENDIAN_STRAP_POS];
      next_st.boot = hpp_boot_t'({host_data_in[HPP_BOOT_HI_POS], host_data_in[HPP_BOOT_LO_POS]});
    end
  end

  // strap register
  always_ff @(posedge mclk)
  begin
    st <= next_st;
  end

  assign endian_little = st.little;
  assign boot_mode = st.boot;

endmodule

// *** rtl/hpp_half_hold.sv ***
// holds the first half-word of a host pair until the second arrives
// assumes capture is a one-cycle pulse from the main sequencer
module hpp_half_hold
  import hpp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // capture side
  input wire logic capture,
  input wire logic [hpp_pkg::HPP_HALF_W-1:0] half_in,
  // held value
  output logic [hpp_pkg::HPP_HALF_W-1:0] half_held
);

  typedef struct packed {
    logic [HPP_HALF_W-1:0] held;
  } hpp_hold_st_t;

  hpp_hold_st_t st;
  hpp_hold_st_t next_st;

  // keep the first half of the pair
  always_comb
  begin
    next_st = st;
    if (capture)
    begin
      next_st.held = half_in;
    end
  end

  // hold register
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st <= '{held: HPP_HALF_ZERO};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign half_held = st.held;

endmodule

// *** rtl/hpp_host_port.sv ***
// device end of a 16-bit parallel host port with boot straps
// assumes host pins synchronous to mclk, a one-cycle-ack memory port,
// and a dsp-side register port with read data one cycle after the strobe
module hpp_host_port
  import hpp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // host control pins
  input wire logic host_strobe_n,
  input wire logic host_reg_select_hi,
  input wire logic host_reg_select_lo,
  input wire logic host_halfword_order,
  input wire logic host_read_not_write,
  // host data bus, split
  input wire logic [hpp_pkg::HPP_HALF_W-1:0] host_data_in,
  output logic [hpp_pkg::HPP_HALF_W-1:0] host_data_out,
  output logic host_data_oe_n,
  // host status pins
  output logic host_access_ready,
  output logic host_irq_out,
  // memory side
  output logic mem_req,
  output logic mem_we,
  output logic [hpp_pkg::HPP_WORD_W-1:0] mem_addr,
  output logic [hpp_pkg::HPP_WORD_W-1:0] mem_wdata,
  input wire logic [hpp_pkg::HPP_WORD_W-1:0] mem_rdata,
  input wire logic mem_ack,
  // dsp register port
  input wire logic [hpp_pkg::HPP_REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic dsp_irq,
  // captured configuration
  output logic endian_little,
  output hpp_pkg::hpp_boot_t boot_mode
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    hpp_state_t fsm;
    logic strobe_q;
    logic irq;
    logic [HPP_WORD_W-1:0] addr;
    logic [HPP_WORD_W-1:0] rd_word;
    logic inc;
    logic [HPP_HALF_W-1:0] dout;
    logic oe_n;
    logic ready;
    logic req;
    logic we;
    logic [HPP_WORD_W-1:0] maddr;
    logic [HPP_WORD_W-1:0] wdata;
    logic [HPP_EV_W-1:0] status;
    logic [HPP_EV_W-1:0] mask;
    logic [31:0] rdata;
    logic dirq;
  } hpp_st_t;

  hpp_st_t st;
  hpp_st_t next_st;
  logic little;
  hpp_boot_t boot;
  logic [HPP_HALF_W-1:0] first_half;
  logic capture_first;
  logic take;
  hpp_sel_t sel;
  logic [HPP_EV_W-1:0] events;

  // ----------------------------------------
  // strap capture and first-half hold
  // ----------------------------------------
  hpp_strap_latch u_straps (
    .mclk(mclk),
    .reset(reset),
    .host_data_in(host_data_in),
    .endian_little(little),
    .boot_mode(boot)
  );

  hpp_half_hold u_hold (
    .mclk(mclk),
    .reset(reset),
    .capture(capture_first),
    .half_in(host_data_in),
    .half_held(first_half)
  );

  // access decode
  assign take = !host_strobe_n && st.strobe_q && (st.fsm == HPP_ST_IDLE);
  assign sel = hpp_sel_t'({host_reg_select_hi, host_reg_select_lo});
  assign capture_first = take && !host_read_not_write && !host_halfword_order
    && (sel != HPP_SEL_CTRL);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    events = '0;
    next_st.strobe_q = host_strobe_n;
    // host side accesses
    if (take)
    begin
      if (!host_read_not_write)
      begin
        case (sel)
          HPP_SEL_CTRL:
          begin
            // host acknowledges the interrupt by writing a one
            if (host_data_in[HPP_CTL_IRQ_BIT])
            begin
              next_st.irq = 1'b0;
              events[HPP_EV_HOST_ACK] = 1'b1;
            end
          end
          HPP_SEL_ADDR:
          begin
            if (host_halfword_order)
            begin
              next_st.addr = hpp_join(first_half, host_data_in, little);
            end
          end
          HPP_SEL_DATA_INC, HPP_SEL_DATA:
          begin
            // second half completes the word and starts the memory write
            if (host_halfword_order)
            begin
              next_st.wdata = hpp_join(first_half, host_data_in, little);
              next_st.maddr = st.addr;
              next_st.we = 1'b1;
              next_st.req = 1'b1;
              next_st.inc = (sel == HPP_SEL_DATA_INC);
              next_st.fsm = HPP_ST_MEM;
            end
          end
          default:
          begin
            next_st.fsm = HPP_ST_IDLE;
          end
        endcase
      end
      else
      begin
        case (sel)
          HPP_SEL_CTRL:
          begin
            next_st.dout = HPP_HALF_ZERO;
            next_st.dout[HPP_CTL_IRQ_BIT] = st.irq;
            next_st.dout[HPP_CTL_ENDIAN_BIT] = little;
            next_st.dout[HPP_CTL_BOOT_POS +: 2] = boot;
          end
          HPP_SEL_ADDR:
          begin
            next_st.dout = hpp_half_of(st.addr, host_halfword_order, little);
          end
          HPP_SEL_DATA_INC, HPP_SEL_DATA:
          begin
            if (!host_halfword_order)
            begin
              // first half fetches the whole word
              next_st.maddr = st.addr;
              next_st.we = 1'b0;
              next_st.req = 1'b1;
              next_st.inc = (sel == HPP_SEL_DATA_INC);
              next_st.fsm = HPP_ST_MEM;
            end
            else
            begin
              next_st.dout = hpp_half_of(st.rd_word, 1'b1, little);
              if (sel == HPP_SEL_DATA_INC)
              begin
                next_st.addr = st.addr + HPP_ADDR_STEP;
              end
            end
          end
          default:
          begin
            next_st.fsm = HPP_ST_IDLE;
          end
        endcase
      end
    end
    // memory completion
    if (st.fsm == HPP_ST_MEM && mem_ack)
    begin
      next_st.req = 1'b0;
      next_st.fsm = HPP_ST_IDLE;
      if (st.we)
      begin
        events[HPP_EV_WORD_WR] = 1'b1;
        if (st.inc)
        begin
          next_st.addr = st.addr + HPP_ADDR_STEP;
        end
      end
      else
      begin
        events[HPP_EV_WORD_RD] = 1'b1;
        next_st.rd_word = mem_rdata;
        next_st.dout = hpp_half_of(mem_rdata, 1'b0, little);
      end
    end
    // bus drive only during a host read strobe
    next_st.oe_n = !(!host_strobe_n && host_read_not_write);
    // ready low while a memory access is outstanding
    next_st.ready = (next_st.fsm == HPP_ST_IDLE);
    // dsp software raises the host interrupt, set beats a host clear
    if (reg_wr && reg_addr == HPP_REG_CONTROL && reg_wdata[HPP_CTL_IRQ_BIT])
    begin
      next_st.irq = 1'b1;
    end
    if (reg_wr && reg_addr == HPP_REG_MASK)
    begin
      next_st.mask = reg_wdata[HPP_EV_W-1:0];
    end
    // register read data, valid in the cycle after the strobe only
    next_st.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        HPP_REG_STATUS:
        begin
          next_st.rdata[HPP_EV_W-1:0] = st.status;
        end
        HPP_REG_MASK:
        begin
          next_st.rdata[HPP_EV_W-1:0] = st.mask;
        end
        HPP_REG_CONTROL:
        begin
          next_st.rdata[HPP_CTL_IRQ_BIT] = st.irq;
        end
        HPP_REG_STRAPS:
        begin
          next_st.rdata[HPP_CTL_ENDIAN_BIT] = little;
          next_st.rdata[HPP_CTL_BOOT_POS +: 2] = boot;
        end
        default:
        begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end
    // sticky status, read clears, new event wins
    next_st.status = ((reg_rd && reg_addr == HPP_REG_STATUS) ? '0 : st.status) | events;
    next_st.dirq = |(next_st.status & next_st.mask);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st <= '{fsm: HPP_ST_IDLE, strobe_q: 1'b1, irq: 1'b0, addr: HPP_ADDR_RESET,
              rd_word: 32'h0000_0000, inc: 1'b0, dout: HPP_HALF_ZERO, oe_n: 1'b1,
              ready: 1'b1, req: 1'b0, we: 1'b0, maddr: HPP_ADDR_RESET,
              wdata: 32'h0000_0000, status: '0, mask: HPP_MASK_RESET,
              rdata: 32'h0000_0000, dirq: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign host_data_out = st.dout;
  assign host_data_oe_n = st.oe_n;
  assign host_access_ready = st.ready;
  assign host_irq_out = st.irq;
  assign mem_req = st.req;
  assign mem_we = st.we;
  assign mem_addr = st.maddr;
  assign mem_wdata = st.wdata;
  assign reg_rdata = st.rdata;
  assign dsp_irq = st.dirq;
  assign endian_little = little;
  assign boot_mode = boot;

endmodule

// *** dv/hpp_host_model.sv ***
// host processor model driving the parallel port pins
// assumes the bench resolves the shared bus from both enables
module hpp_host_model
  import hpp_pkg::*;
(
  // clock
  input wire logic mclk,
  // control pins
  output logic strobe_n,
  output logic sel_hi,
  output logic sel_lo,
  output logic hw,
  output logic rnw,
  // bus and status
  output logic [15:0] dq,
  output logic dq_en,
  input wire logic [15:0] bus,
  input wire logic ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // host access tasks
  // ----------------------------------------
  // strobe idles high, other pins low, bus released
  initial
  begin
    {strobe_n, sel_hi, sel_lo, hw, rnw, dq_en} = 6'h20;
    dq = 16'h0000;
  end

  // strap drive or release of the bus
  task automatic drive(input logic en, input logic [15:0] v);
    dq <= v;
    dq_en <= en;
  endtask

  // one half-word access, strobe held until ready seen high
  // no local limit: a ready that never comes trips the bench timeout
  task automatic xfer(input hpp_sel_t sel, input logic h, input logic r, input logic [15:0] wd,
                      output logic [15:0] rd);
    @(posedge mclk);
    {sel_hi, sel_lo} <= sel;
    hw <= h;
    rnw <= r;
    drive(!r, wd);
    strobe_n <= 1'b0;
    do
    begin
      @(posedge mclk);
      #1;
    end
    while (ready !== 1'b1);
    rd = bus;
    @(posedge mclk);
    strobe_n <= 1'b1;
    dq_en <= 1'b0;
  endtask

  // word as first then second half, same select and direction
  task automatic word(input hpp_sel_t sel, input logic r, input logic lit, input logic [31:0] wd,
                      output logic [31:0] rd);
    logic [15:0] a;
    logic [15:0] b;
    xfer(sel, 1'b0, r, lit ? wd[15:0] : wd[31:16], a);
    xfer(sel, 1'b1, r, lit ? wd[31:16] : wd[15:0], b);
    rd = lit ? {b, a} : {a, b};
  endtask
endmodule

// *** dv/hpp_host_port_assertions.sv ***
// assertions on the host port pins and register port
// assumes binding into hpp_host_port, one clock mclk
module hpp_chk
  import hpp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // host pins
  input wire logic host_strobe_n,
  input wire logic host_read_not_write,
  input wire logic [hpp_pkg::HPP_HALF_W-1:0] host_data_in,
  input wire logic host_data_oe_n,
  input wire logic host_access_ready,
  input wire logic host_irq_out,
  // memory side
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [hpp_pkg::HPP_WORD_W-1:0] mem_addr,
  input wire logic mem_ack,
  // register port and straps
  input wire logic [hpp_pkg::HPP_REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic endian_little,
  input wire hpp_pkg::hpp_boot_t boot_mode
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_reset_values: assert property ($fell(reset) |-> host_data_oe_n && host_access_ready
    && !mem_req && !host_irq_out) else $error("outputs not idle after reset");
  a_endian_strap: assert property ($fell(reset) |-> endian_little == $past(host_data_in[8]))
    else $error("byte order strap not taken");
  a_boot_strap: assert property ($fell(reset) |-> boot_mode == $past(host_data_in[4:3]))
    else $error("boot strap not taken");
  a_straps_frozen: assert property (!$fell(reset) |-> $stable(endian_little) && $stable(boot_mode))
    else $error("straps moved after reset");
  a_ready_busy: assert property (mem_req |-> !host_access_ready)
    else $error("ready high during memory access");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request dropped early");
  a_ack_done: assert property (mem_req && mem_ack |=> !mem_req && host_access_ready)
    else $error("ready not back after ack");
  a_read_drive: assert property (host_access_ready && !host_strobe_n && $past(host_strobe_n)
    && host_read_not_write |=> !host_data_oe_n) else $error("bus not driven on read");
  a_irq_raise: assert property (reg_wr && reg_addr == HPP_REG_CONTROL && reg_wdata[0]
    |=> host_irq_out) else $error("host interrupt not raised");

  // main scenarios
  c_mem_write: cover property (mem_ack && mem_we);
  c_mem_read: cover property (mem_ack && !mem_we);
  c_host_irq: cover property ($fell(host_irq_out));
endmodule

bind hpp_host_port hpp_chk u_chk (.mclk, .reset, .host_strobe_n, .host_read_not_write, .host_data_in,
  .host_data_oe_n, .host_access_ready, .host_irq_out, .mem_req, .mem_we, .mem_addr, .mem_ack,
  .reg_addr, .reg_wdata, .reg_wr, .endian_little, .boot_mode);

// *** dv/hpp_host_port_test.sv ***
// testbench for hpp_host_port with host model and memory responder
// assumes pull-ups on the bus except a pull-down on bit 4
module hpp_host_port_test
  import hpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset, strobe_n, sel_hi, sel_lo, hw, rnw, dq_en, oe_n, ready, hirq;
  logic mem_req, mem_we, reg_wr, reg_rd, dsp_irq, endian_little;
  logic mem_ack = 1'b0;
  logic dly = 1'b0;
  logic [15:0] dq, bus, dout, h;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, reg_wdata, reg_rdata, last_a, last_d, w;
  logic [3:0] reg_addr;
  hpp_boot_t boot_mode;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  // ----------------------------------------
  // structure
  // ----------------------------------------
  // bus level from both enables, pulls when released
  assign bus = !oe_n ? dout : (dq_en ? dq : 16'hFFEF);
  assign mem_rdata = mem_addr ^ 32'h5A5A_0000;
  hpp_host_model host (.mclk(mclk), .strobe_n(strobe_n), .sel_hi(sel_hi), .sel_lo(sel_lo), .hw(hw),
    .rnw(rnw), .dq(dq), .dq_en(dq_en), .bus(bus), .ready(ready));
  hpp_host_port uut (.mclk(mclk), .reset(reset), .host_strobe_n(strobe_n), .host_reg_select_hi(sel_hi),
    .host_reg_select_lo(sel_lo), .host_halfword_order(hw), .host_read_not_write(rnw),
    .host_data_in(bus), .host_data_out(dout), .host_data_oe_n(oe_n), .host_access_ready(ready),
    .host_irq_out(hirq), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dsp_irq(dsp_irq), .endian_little(endian_little), .boot_mode(boot_mode));

  // clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // memory responder, ack two cycles after request, records writes
  always @(posedge mclk)
  begin
    dly <= mem_req && !mem_ack && !dly;
    mem_ack <= dly;
    if (mem_ack && mem_we)
    begin
      last_a <= mem_addr;
      last_d <= mem_wdata;
    end
  end

  // hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      summarize();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rw(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data checked in the one cycle it stands
  task automatic rr(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  task automatic rst(input logic [15:0] v);
    @(posedge mclk);
    host.drive(1'b1, v);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    host.drive(1'b0, v);
    // let the frozen straps settle before anyone looks
    @(posedge mclk);
    #1;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    // reset high from time zero so no edge runs on unknown state
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    // every boot mode, both byte orders
    for (int i = 0; i < 4; i++)
    begin
      rst({7'h00, i[0], 3'h0, i[1:0], 3'h0});
      chk("endian", i[0], endian_little);
      chk("boot", i[1:0], boot_mode);
      rr(HPP_REG_STRAPS, {i[1:0], i[0], 1'b0}, "straps reg");
    end
    $display("test straps done");
    host.word(HPP_SEL_ADDR, 1'b0, 1'b1, 32'h0000_0100, w);
    host.word(HPP_SEL_DATA, 1'b0, 1'b1, 32'hCAFE_1234, w);
    chk("mem addr", 32'h0000_0100, last_a);
    chk("mem data", 32'hCAFE_1234, last_d);
    chk("dsp irq masked", 32'h0, dsp_irq);
    rw(HPP_REG_MASK, 32'h0000_0001);
    @(posedge mclk);
    #1;
    chk("dsp irq", 32'h1, dsp_irq);
    rr(HPP_REG_STATUS, 32'h1, "status write");
    @(posedge mclk);
    #1;
    chk("dsp irq cleared", 32'h0, dsp_irq);
    $display("test host write done");
    host.word(HPP_SEL_DATA_INC, 1'b1, 1'b1, 32'h0, w);
    chk("host read", 32'h5A5A_0100, w);
    host.word(HPP_SEL_ADDR, 1'b1, 1'b1, 32'h0, w);
    chk("addr step", 32'h0000_0104, w);
    rr(HPP_REG_STATUS, 32'h2, "status read");
    $display("test host read done");
    rw(HPP_REG_CONTROL, 32'h0000_0001);
    @(posedge mclk);
    #1;
    chk("host irq", 32'h1, hirq);
    host.xfer(HPP_SEL_CTRL, 1'b0, 1'b1, 16'h0000, h);
    chk("ctrl read", 32'h0000_000F, h);
    host.xfer(HPP_SEL_CTRL, 1'b0, 1'b0, 16'h0001, h);
    chk("host irq ack", 32'h0, hirq);
    rr(HPP_REG_STATUS, 32'h4, "status ack");
    rr(HPP_REG_MASK, 32'h1, "mask");
    rr(4'h6, 32'h0, "unmapped");
    $display("test irq done");
    // big endian: first half carries the upper bits
    rst(16'h0010);
    host.word(HPP_SEL_ADDR, 1'b0, 1'b0, 32'h0000_0200, w);
    host.word(HPP_SEL_DATA_INC, 1'b0, 1'b0, 32'h1357_9BDF, w);
    chk("big mem addr", 32'h0000_0200, last_a);
    chk("big mem data", 32'h1357_9BDF, last_d);
    host.word(HPP_SEL_DATA, 1'b1, 1'b0, 32'h0, w);
    chk("big host read", 32'h5A5A_0204, w);
    $display("test big endian done");
    summarize();
  end
endmodule
